// >>> hw/csw_pkg.sv
package csw_pkg;
	// Register offsets, memory-mapped view above the socket base
	localparam logic [11:0] CSW_OFS_FLAGS = 12'h804;
	localparam logic [11:0] CSW_OFS_CONFIG = 12'h805;
	localparam logic [11:0] CSW_OFS_WIN_EN = 12'h806;
	// Legacy per-socket offsets, low byte of the legacy window
	localparam logic [7:0] CSW_LEG_FLAGS = 8'h04;
	localparam logic [7:0] CSW_LEG_CONFIG = 8'h05;
	localparam logic [7:0] CSW_LEG_WIN_EN = 8'h06;
	localparam logic [7:0] CSW_LEG_SOCKET_A = 8'h00;
	localparam logic [7:0] CSW_LEG_SOCKET_B = 8'h40;
	// Configuration register fields
	localparam int CSW_SEL_MSB = 7;
	localparam int CSW_SEL_LSB = 4;
	localparam int CSW_CD_EN_BIT = 3;
	localparam int CSW_READY_EN_BIT = 2;
	localparam int CSW_BWARN_EN_BIT = 1;
	localparam int CSW_BDEAD_EN_BIT = 0;
	localparam logic [3:0] CSW_SEL_NONE = 4'h0;
	localparam logic [3:0] CSW_SEL_SMI = 4'h2;
	// Window enable register fields
	localparam int CSW_IO_WIN_LSB = 6;
	localparam int CSW_RSVD_BIT = 5;
	localparam logic [7:0] CSW_WIN_EN_WMASK = 8'hDF;
	// Reset values
	localparam logic [7:0] CSW_CONFIG_RST = 8'h00;
	localparam logic [7:0] CSW_WIN_EN_RST = 8'h00;
	localparam logic [3:0] CSW_FLAGS_RST = 4'h0;
	// Idle pin levels: card detect pins high, the rest low
	localparam logic [4:0] CSW_PINS_IDLE = 5'h18;

	typedef struct packed {
		logic [11:0] addr;
		logic legacy;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} csw_req_type;

	typedef struct packed {
		logic card_detect_a_n;
		logic card_detect_b_n;
		logic ready;
		logic battery_warn;
		logic card_status_change_pin;
	} csw_pins_type;

	typedef struct packed {
		logic pci;
		logic smi;
		logic [15:0] irq;
	} csw_irq_type;
endpackage

// >>> hw/csw_socket_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Select 0000 with the diagnostic PCI bit set sends status change to PCI, route bit ignored.
// - Select 0000 with the diagnostic bit clear drives no legacy line; PCI only if route bit set.
// - Config bits 7-4 are the line select; 0010 means SMI, 0000 is the default with no line.
// - Other nonzero select codes drive IRQ n where n is the code value.
// - Config bit 3 lets card detect changes raise a status change; default off.
// - Config bit 2 lets a READY rising edge raise a status change; default off.
// - Config bit 1 lets battery warning raise a status change; default off.
// - Config bit 0 lets battery dead or status-change pin raise a status change; default off.
// - No card cycle is claimed through a window whose enable bit is 0.
// - Window enable bits 7 and 6 enable I/O windows 1 and 0; default off.
// - Window enable bits 4 to 0 enable memory windows 4 to 0; default off.
// - Window enable bit 5 is read-only and reads 0.
// - The window enable register reads 00h after reset.
// - Window enable sits at legacy 06h or 46h and at 806h above the socket base.
// - Route bit set sends status change to PCI; clear means the line select decides.
// - A flag whose source is disabled reads 0; enabled sources set their flag on the event.
module csw_socket_ctrl #(
	parameter logic [7:0] LEGACY_BASE = csw_pkg::CSW_LEG_SOCKET_A
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// Register access
	input wire csw_pkg::csw_req_type i_req,
	output logic [7:0] o_reg_rdata,
	// Card pins, asynchronous
	input wire csw_pkg::csw_pins_type i_pins,
	// Routing bits kept elsewhere in the controller
	input wire logic i_status_change_pci_route,
	input wire logic i_diag_status_change_pci,
	// Window hits from the address decoders
	input wire logic [1:0] i_io_win_hit,
	input wire logic [4:0] i_mem_win_hit,
	output logic [1:0] o_io_win_claim,
	output logic [4:0] o_mem_win_claim,
	// Status-change interrupt outputs
	output csw_pkg::csw_irq_type o_irq
);
	import csw_pkg::*;

	csw_pins_type sync1_q, sync2_q, prev_q;
	logic [7:0] config_q, config_d;
	logic [7:0] win_en_q, win_en_d;
	logic [3:0] flags_q, flags_d;
	logic [7:0] rdata_q, rdata_d;
	logic [3:0] enables, events, flags_rd;
	logic hit_flags, hit_config, hit_win_en, any_flag;
	logic [3:0] sel;

	// Two-stage synchroniser, then one delayed copy for edge detection
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			// Idle levels, so that leaving reset shows no false pin edge
			sync1_q <= csw_pins_type'(CSW_PINS_IDLE);
			sync2_q <= csw_pins_type'(CSW_PINS_IDLE);
			prev_q <= csw_pins_type'(CSW_PINS_IDLE);
		end else begin
			sync1_q <= i_pins;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// Either socket view reaches the same registers
	always_comb begin
		hit_flags = i_req.legacy ? (i_req.addr[7:0] == (LEGACY_BASE | CSW_LEG_FLAGS))
			: (i_req.addr == CSW_OFS_FLAGS);
		hit_config = i_req.legacy ? (i_req.addr[7:0] == (LEGACY_BASE | CSW_LEG_CONFIG))
			: (i_req.addr == CSW_OFS_CONFIG);
		hit_win_en = i_req.legacy ? (i_req.addr[7:0] == (LEGACY_BASE | CSW_LEG_WIN_EN))
			: (i_req.addr == CSW_OFS_WIN_EN);
	end

	always_comb begin
		enables = config_q[3:0];
		events[CSW_CD_EN_BIT] = (sync2_q.card_detect_a_n != prev_q.card_detect_a_n) ||
			(sync2_q.card_detect_b_n != prev_q.card_detect_b_n);
		events[CSW_READY_EN_BIT] = sync2_q.ready && !prev_q.ready;
		events[CSW_BWARN_EN_BIT] = sync2_q.battery_warn && !prev_q.battery_warn;
		events[CSW_BDEAD_EN_BIT] = sync2_q.card_status_change_pin &&
			!prev_q.card_status_change_pin;
		flags_rd = flags_q & enables;
		config_d = config_q;
		win_en_d = win_en_q;
		flags_d = flags_q;
		if (i_req.wr && hit_config) begin
			config_d = i_req.wdata;
		end
		if (i_req.wr && hit_win_en) begin
			win_en_d = i_req.wdata & CSW_WIN_EN_WMASK;
		end
		if (i_req.wr && hit_flags) begin
			flags_d = flags_q & ~i_req.wdata[3:0];
		end
		// Set wins over a clear in the same cycle; masking with the enables about
		// to take effect keeps a disabled source from holding a flag
		flags_d = (flags_d | (events & enables)) & config_d[3:0];
		rdata_d = rdata_q;
		if (i_req.rd) begin
			if (hit_flags) begin
				rdata_d = {4'h0, flags_rd};
			end else if (hit_config) begin
				rdata_d = config_q;
			end else if (hit_win_en) begin
				rdata_d = win_en_q & CSW_WIN_EN_WMASK;
			end else begin
				rdata_d = 8'h00;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			config_q <= CSW_CONFIG_RST;
			win_en_q <= CSW_WIN_EN_RST;
			flags_q <= CSW_FLAGS_RST;
			rdata_q <= 8'h00;
		end else begin
			config_q <= config_d;
			win_en_q <= win_en_d;
			flags_q <= flags_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_reg_rdata = rdata_q;

	// Claims only pass through enabled windows
	assign o_io_win_claim = i_io_win_hit & win_en_q[CSW_IO_WIN_LSB +: 2];
	assign o_mem_win_claim = i_mem_win_hit & win_en_q[4:0];

	assign sel = config_q[CSW_SEL_MSB:CSW_SEL_LSB];
	assign any_flag = |flags_rd;

	always_comb begin
		o_irq.pci = any_flag && (i_status_change_pci_route ||
			(sel == CSW_SEL_NONE && i_diag_status_change_pci));
		o_irq.smi = any_flag && !i_status_change_pci_route && (sel == CSW_SEL_SMI);
		o_irq.irq = 16'h0000;
		if (any_flag && !i_status_change_pci_route && sel != CSW_SEL_NONE &&
			sel != CSW_SEL_SMI) begin
			o_irq.irq[sel] = 1'b1;
		end
	end

	sequence s_ready_rise;
		!prev_q.ready && sync2_q.ready;
	endsequence
	sequence s_flag_up;
		##1 flags_q[CSW_READY_EN_BIT];
	endsequence
	sequence s_cd_change;
		(sync2_q.card_detect_a_n != prev_q.card_detect_a_n) ||
		(sync2_q.card_detect_b_n != prev_q.card_detect_b_n);
	endsequence
	sequence s_cd_flag_up;
		##1 flags_q[CSW_CD_EN_BIT];
	endsequence
	sequence s_warn_rise;
		!prev_q.battery_warn && sync2_q.battery_warn;
	endsequence
	sequence s_warn_flag_up;
		##1 flags_q[CSW_BWARN_EN_BIT];
	endsequence
	sequence s_dead_rise;
		!prev_q.card_status_change_pin && sync2_q.card_status_change_pin;
	endsequence
	sequence s_dead_flag_up;
		##1 flags_q[CSW_BDEAD_EN_BIT];
	endsequence

	a_ready_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(s_ready_rise and (config_q[CSW_READY_EN_BIT] && config_d[CSW_READY_EN_BIT]))
		|-> s_flag_up)
		else $error("ready rise not flagged");
	a_cd_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(s_cd_change and (config_q[CSW_CD_EN_BIT] && config_d[CSW_CD_EN_BIT]))
		|-> s_cd_flag_up)
		else $error("card detect change not flagged");
	a_warn_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(s_warn_rise and (config_q[CSW_BWARN_EN_BIT] && config_d[CSW_BWARN_EN_BIT]))
		|-> s_warn_flag_up)
		else $error("battery warning not flagged");
	a_dead_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(s_dead_rise and (config_q[CSW_BDEAD_EN_BIT] && config_d[CSW_BDEAD_EN_BIT]))
		|-> s_dead_flag_up)
		else $error("battery dead not flagged");
	a_disabled_reads_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(flags_q & ~config_q[3:0]) == 4'h0)
		else $error("disabled flag held");
	a_pci_diag_route: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		any_flag && sel == CSW_SEL_NONE && i_diag_status_change_pci |-> o_irq.pci)
		else $error("diag pci route missed");
	a_no_legacy_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		sel == CSW_SEL_NONE |-> !o_irq.smi && o_irq.irq == 16'h0000)
		else $error("legacy line at select zero");
	a_smi_select: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		any_flag && !i_status_change_pci_route && sel == CSW_SEL_SMI |-> o_irq.smi)
		else $error("smi not driven");
	a_irq_line: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		o_irq.irq != 16'h0000 |-> o_irq.irq == (16'h0001 << sel) && sel != CSW_SEL_SMI)
		else $error("wrong irq line");
	a_claim_gated: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(o_mem_win_claim & ~win_en_q[4:0]) == 5'h00 &&
		(o_io_win_claim & ~win_en_q[7:6]) == 2'h0)
		else $error("claim through disabled window");
	a_rsvd_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		i_req.rd && hit_win_en |=> !o_reg_rdata[CSW_RSVD_BIT] && !win_en_q[CSW_RSVD_BIT])
		else $error("reserved bit set");
	a_win_en_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		i_req.wr && hit_win_en |=> win_en_q == ($past(i_req.wdata) & CSW_WIN_EN_WMASK))
		else $error("window enable write lost");
	a_irq_drops: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!any_flag |-> !o_irq.pci && !o_irq.smi && o_irq.irq == 16'h0000)
		else $error("irq without flag");
	a_route_pci: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		any_flag && i_status_change_pci_route |->
		o_irq.pci && !o_irq.smi && o_irq.irq == 16'h0000)
		else $error("route bit not honoured");
	a_io_claim: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		o_io_win_claim[1] == (i_io_win_hit[1] && win_en_q[7]) &&
		o_io_win_claim[0] == (i_io_win_hit[0] && win_en_q[6]))
		else $error("io window claim wrong");
	a_mem_claim: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		(i_mem_win_hit & win_en_q[4:0] & ~o_mem_win_claim) == 5'h00)
		else $error("enabled memory window not claimed");
	a_win_en_reset: assert property (@(posedge i_mclk) $rose(i_rstn) |->
		win_en_q == CSW_WIN_EN_RST && o_reg_rdata == 8'h00)
		else $error("window enable not cleared by reset");
endmodule // csw_socket_ctrl

// >>> sim/csw_card_model.sv
`timescale 1ns/1ps
module csw_card_model (
	// Clock and pin levels requested by the bench
	input wire logic i_mclk,
	input wire logic [4:0] i_lvl,
	// Pins seen by the socket logic
	output csw_pkg::csw_pins_type o_pins
);
	import csw_pkg::*;
	// Card pins move on a clock edge, taking the level the bench requested before that edge
	always_ff @(posedge i_mclk) begin
		o_pins <= csw_pins_type'(i_lvl);
	end
endmodule // csw_card_model

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import csw_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	csw_req_type req = '0;
	logic [7:0] rdata;
	logic route = 1'b0;
	logic diag = 1'b0;
	logic [1:0] io_hit = '0;
	logic [4:0] mem_hit = '0;
	logic [1:0] io_claim;
	logic [4:0] mem_claim;
	csw_irq_type irq;
	csw_pins_type pins;
	logic [4:0] lvl = 5'b11000;
	logic [7:0] we;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	always #10 i_mclk = ~i_mclk;
	csw_card_model card (.i_mclk(i_mclk), .i_lvl(lvl), .o_pins(pins));
	csw_socket_ctrl uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(req), .o_reg_rdata(rdata),
		.i_pins(pins), .i_status_change_pci_route(route), .i_diag_status_change_pci(diag),
		.i_io_win_hit(io_hit), .i_mem_win_hit(mem_hit), .o_io_win_claim(io_claim),
		.o_mem_win_claim(mem_claim), .o_irq(irq));
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		checks_done++;
		if (seen !== expv) begin
			failures++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, expv);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic leg, input logic [7:0] d);
		@(posedge i_mclk) #1;
		req = '{addr: a, legacy: leg, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge i_mclk) #1;
		req.wr = 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic leg, input logic [7:0] expv);
		@(posedge i_mclk) #1;
		req = '{addr: a, legacy: leg, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge i_mclk) #1;
		req.rd = 1'b0;
		chk(rdata, expv);
	endtask
	// Expected interrupt outputs; the route bit overrides the line select
	function automatic csw_irq_type model(logic [3:0] sel, logic rt, logic dg, logic any);
		csw_irq_type m;
		m = '0;
		m.pci = any & (rt | (sel == 4'h0 & dg));
		m.smi = any & !rt & (sel == 4'h2);
		if (any && !rt && sel != 4'h0 && sel != 4'h2)
			m.irq[sel] = 1'b1;
		return m;
	endfunction
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(58));
		repeat (16) @(posedge i_mclk);
		#1 i_rstn = 1'b1;
		rd(12'h806, 1'b0, 8'h00);
		rd(12'h805, 1'b0, 8'h00);
		$display("reset values done");
		for (int k = 0; k < 4; k++) begin
			we = 8'($urandom());
			wr(12'h806, 1'b0, we);
			rd(12'h006, 1'b1, we & 8'hDF);
			io_hit = 2'($urandom());
			mem_hit = 5'($urandom());
			#1 chk({io_claim, mem_claim}, {io_hit & we[7:6], mem_hit & we[4:0]});
		end
		rd(12'h046, 1'b1, 8'h00);
		$display("window enable done");
		@(posedge i_mclk) #1;
		i_rstn = 1'b0;
		repeat (2) @(posedge i_mclk);
		#1 i_rstn = 1'b1;
		#1 chk({io_claim, mem_claim}, 7'h00);
		rd(12'h806, 1'b0, 8'h00);
		$display("second reset done");
		wr(12'h805, 1'b0, 8'h0B);
		rd(12'h005, 1'b1, 8'h0B);
		lvl = 5'b01111;
		repeat (8) @(posedge i_mclk);
		rd(12'h804, 1'b0, 8'h0B);
		chk(irq, model(4'h0, 1'b0, 1'b0, 1'b1));
		wr(12'h804, 1'b0, 8'h0F);
		lvl[2] = 1'b0;
		$display("source enables done");
		for (int s = 0; s < 16; s++) begin
			route = 1'($urandom());
			diag = 1'($urandom());
			wr(12'h805, 1'b0, {4'(s), 4'h4});
			lvl[2] = 1'b1;
			repeat (6) @(posedge i_mclk);
			#1 chk(irq, model(4'(s), route, diag, 1'b1));
			wr(12'h804, 1'b0, 8'h04);
			lvl[2] = 1'b0;
			#1 chk(irq, model(4'(s), route, diag, 1'b0));
		end
		$display("routing done");
		tally_and_finish();
	end
endmodule // testbench
